// >>> common/supply_seq_pkg.sv
// Constants shared by the supply startup sequencer and its soft-start ramps
package supply_seq_pkg;
    // Core clock rate
    localparam int CORE_CLK_MHZ = 125;

    // Soft-start: reference steps and switching cycles per step
    localparam int SS_STEPS = 32;
    localparam int SS_TICKS_SLOW = 32;
    localparam int SS_TICKS_FAST = 64;
    localparam int SS_CODE_W = 6;
    localparam int SS_PRESC_W = 6;
    localparam logic [SS_CODE_W-1:0] SS_CODE_FULL = SS_CODE_W'(SS_STEPS);
    localparam logic [SS_CODE_W-1:0] SS_CODE_ZERO = 6'h00;
    localparam logic [SS_PRESC_W-1:0] SS_LAST_SLOW =
        SS_PRESC_W'(SS_TICKS_SLOW - 1);
    localparam logic [SS_PRESC_W-1:0] SS_LAST_FAST =
        SS_PRESC_W'(SS_TICKS_FAST - 1);

    // Regulators: step-down plus five linear controllers
    localparam int NUM_REG = 6;
    localparam int NUM_SEQ = 4;
    localparam int REG_BUCK = 0;
    localparam int REG_LOGIC = 1;
    localparam int REG_GATE_OFF = 5;

    // Timing in microseconds and derived core-clock counts
    localparam int OC_FILTER_US = 50;
    localparam int OC_FILTER_CYCLES = OC_FILTER_US * CORE_CLK_MHZ;
    localparam int FAULT_TIMER_US = 1000;
    localparam int FAULT_TIMER_CYCLES = FAULT_TIMER_US * CORE_CLK_MHZ;
    localparam int RESET_TIMEOUT_US = 200;
    localparam int RESET_TIMEOUT_CYCLES = RESET_TIMEOUT_US * CORE_CLK_MHZ;
    localparam int CNT_W = 24;

    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_FAULT_TIME = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RESET_TIME = 8'h08;

    // Status word bit positions
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_THERMAL_BIT = 1;
    localparam int ST_BUCK_BIT = 2;
    localparam int ST_RAIL_LSB = 3;
    localparam int ST_SUP_REL_BIT = 8;
    localparam int ST_STATE_LSB = 9;
    localparam int ST_SUPPLY_BIT = 11;
    localparam int ST_ENABLE_BIT = 12;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Startup sequencer states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_BUCK_SS = 2'b01,
        ST_LOGIC_SS = 2'b10,
        ST_RUN = 2'b11
    } seq_state_t;
endpackage : supply_seq_pkg

// >>> hw/soft_start_ramp.sv
// Soft-start reference ramp for one regulator
`timescale 1ns/1ps
module soft_start_ramp
    import supply_seq_pkg::*;
#(
    parameter bit DOWN = 1'b0
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic tick,
    input wire logic fast_rate,
    output logic [SS_CODE_W-1:0] code,
    output logic done
);
    localparam logic [SS_CODE_W-1:0] START_CODE =
        DOWN ? SS_CODE_FULL : SS_CODE_ZERO;
    localparam logic [SS_CODE_W-1:0] END_CODE =
        DOWN ? SS_CODE_ZERO : SS_CODE_FULL;

    logic [SS_PRESC_W-1:0] presc_reg;
    logic [SS_CODE_W-1:0] code_reg;
    logic done_reg;
    logic [SS_CODE_W-1:0] code_next;
    logic last_tick;

    // Step period doubles at the fast rate so the ramp time is unchanged
    assign last_tick = presc_reg == (fast_rate ? SS_LAST_FAST : SS_LAST_SLOW);
    assign code_next = DOWN ? code_reg - 6'h01 : code_reg + 6'h01;
    assign code = code_reg;
    assign done = done_reg;

    // Restart from the start code on every enable
    always_ff @(posedge core_clk) begin
        if (reset || !enable) begin
            presc_reg <= '0;
            code_reg <= START_CODE;
            done_reg <= 1'b0;
        end else if (tick && !done_reg) begin
            if (last_tick) begin
                presc_reg <= '0;
                code_reg <= code_next;
                done_reg <= code_next == END_CODE;
            end else begin
                presc_reg <= presc_reg + 6'h01;
            end
        end
    end
endmodule : soft_start_ramp

// >>> hw/supply_startup_sequencer.sv
// Digital core of the multi-rail supply startup sequencer
`timescale 1ns/1ps
module supply_startup_sequencer
    import supply_seq_pkg::*;
#(
    parameter int OC_FILTER_LEN = OC_FILTER_CYCLES,
    parameter int FAULT_TIME_INIT = FAULT_TIMER_CYCLES,
    parameter int RESET_TIME_INIT = RESET_TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic enable_above,
    input wire logic supply_ok,
    input wire logic sequence_select,
    input wire logic [NUM_SEQ-1:0] sequence_delay_pin_reached,
    input wire logic [NUM_REG-1:0] rail_undervoltage,
    input wire logic overcurrent_raw,
    input wire logic thermal_trip,
    input wire logic supervisor_sense_ok,
    input wire logic switching_rate_select,
    input wire logic switch_tick,
    input wire logic pwm_high_request,
    input wire logic pwm_low_request,
    output logic high_side_gate_drive,
    output logic low_side_gate_drive,
    output logic step_down_enable,
    output logic logic_rail_controller_enable,
    output logic gamma_rail_controller_enable,
    output logic third_rail_controller_enable,
    output logic source_drive_rail_controller_enable,
    output logic gate_off_rail_controller_enable,
    output logic internal_supply_rail_enable,
    output logic sequence_block_enable,
    output logic delay_pin_current_enable,
    output logic delay_pin_pulldown_enable,
    output logic [NUM_REG*SS_CODE_W-1:0] ref_dac_codes,
    output logic supervisor_reset_out,
    output logic supervisor_reset_oe,
    output logic fault_latched,
    output logic thermal_latched,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp
);
    localparam logic [CNT_W-1:0] OC_LAST = CNT_W'(OC_FILTER_LEN - 1);
    localparam logic [CNT_W-1:0] FAULT_INIT = CNT_W'(FAULT_TIME_INIT);
    localparam logic [CNT_W-1:0] RESET_INIT = CNT_W'(RESET_TIME_INIT);
    localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

    seq_state_t state_reg, state_next;
    logic enable_prev_reg, seq_prev_reg, supply_prev_reg;
    logic fault_reg, thermal_reg;
    logic [NUM_SEQ-1:0] seq_rail_reg;
    logic buck_en_reg, logic_en_reg, seq_block_reg;
    logic hs_reg, ls_reg, vl_en_reg;
    logic cur_en_reg, pulldown_reg;
    logic [CNT_W-1:0] oc_cnt_reg, uv_cnt_reg, sup_cnt_reg;
    logic sup_oe_reg, sup_out_reg;
    logic [CNT_W-1:0] fault_time_reg, reset_time_reg;
    logic [NUM_REG-1:0] ss_done;
    logic [NUM_REG-1:0] ss_enable;

    // Edge detection; inputs are already synchronous to core_clk
    logic enable_rise, seq_rise, supply_rise;
    assign enable_rise = enable_above && !enable_prev_reg;
    assign seq_rise = sequence_select && !seq_prev_reg;
    assign supply_rise = supply_ok && !supply_prev_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            enable_prev_reg <= 1'b0;
            seq_prev_reg <= 1'b0;
            supply_prev_reg <= 1'b0;
        end else begin
            enable_prev_reg <= enable_above;
            seq_prev_reg <= sequence_select;
            supply_prev_reg <= supply_ok;
        end
    end

    // Overcurrent filter: must stay high the full filter length
    logic oc_trip;
    assign oc_trip = overcurrent_raw && (oc_cnt_reg == OC_LAST);

    always_ff @(posedge core_clk) begin
        if (reset || !overcurrent_raw) begin
            oc_cnt_reg <= '0;
        end else if (oc_cnt_reg != OC_LAST) begin
            oc_cnt_reg <= oc_cnt_reg + CNT_ONE;
        end
    end

    // Undervoltage fault timer; only regulators past soft-start count
    logic uv_any, uv_trip;
    assign uv_any = |(rail_undervoltage & ss_done);
    assign uv_trip = uv_any && (uv_cnt_reg >= fault_time_reg);

    // Any break in the condition restarts the timer
    always_ff @(posedge core_clk) begin
        if (reset || !uv_any) begin
            uv_cnt_reg <= '0;
        end else if (!uv_trip) begin
            uv_cnt_reg <= uv_cnt_reg + CNT_ONE;
        end
    end

    // Fault latch: a set in the clearing cycle wins
    logic fault_set, fault_clear, fault_next;
    assign fault_set = uv_trip || oc_trip;
    assign fault_clear = enable_rise || seq_rise || supply_rise;
    assign fault_next = fault_set ? 1'b1 :
                        fault_clear ? 1'b0 : fault_reg;

    // Thermal latch clears only on a supply power cycle
    logic thermal_next;
    assign thermal_next = thermal_trip ? 1'b1 :
                          supply_rise ? 1'b0 : thermal_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_reg <= 1'b0;
            thermal_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            thermal_reg <= thermal_next;
        end
    end

    // Overall run permission
    logic run_ok;
    assign run_ok = supply_ok && enable_above &&
                    !fault_next && !thermal_next;

    // Startup sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (run_ok) begin
                    state_next = ST_BUCK_SS;
                end
            end
            ST_BUCK_SS: begin
                if (ss_done[REG_BUCK]) begin
                    state_next = ST_LOGIC_SS;
                end
            end
            ST_LOGIC_SS: begin
                if (ss_done[REG_LOGIC]) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (!run_ok) begin
            state_next = ST_OFF;
        end
    end

    // Enables derived from the next state so outputs track it exactly
    logic buck_en_next, logic_en_next, seq_block_next, seq_drive_next;
    assign buck_en_next = state_next != ST_OFF;
    assign logic_en_next = (state_next == ST_LOGIC_SS) ||
                           (state_next == ST_RUN);
    assign seq_block_next = buck_en_next;
    assign seq_drive_next = sequence_select && seq_block_next;

    // Sequenced rails latch on once their delay pin crosses threshold
    logic [NUM_SEQ-1:0] seq_rail_next;
    assign seq_rail_next = seq_block_next ?
        (seq_rail_reg | sequence_delay_pin_reached) : '0;

    // Gate drives follow the modulator only when the step-down is enabled and out of lockout
    logic hs_next, ls_next;
    assign hs_next = pwm_high_request && supply_ok && buck_en_reg;
    assign ls_next = pwm_low_request && supply_ok && buck_en_reg;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= ST_OFF;
            buck_en_reg <= 1'b0;
            logic_en_reg <= 1'b0;
            seq_block_reg <= 1'b0;
            seq_rail_reg <= '0;
            cur_en_reg <= 1'b0;
            pulldown_reg <= 1'b1;
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
            vl_en_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            buck_en_reg <= buck_en_next;
            logic_en_reg <= logic_en_next;
            seq_block_reg <= seq_block_next;
            seq_rail_reg <= seq_rail_next;
            cur_en_reg <= seq_drive_next;
            pulldown_reg <= !seq_drive_next;
            hs_reg <= hs_next;
            ls_reg <= ls_next;
            vl_en_reg <= !thermal_next;
        end
    end

    // Soft-start ramps: one per regulator, gate-off ramps down
    assign ss_enable = {seq_rail_reg, logic_en_reg, buck_en_reg};

    genvar r;
    generate
        for (r = 0; r < NUM_REG; r++) begin : g_ramp
            soft_start_ramp #(
                .DOWN(r == REG_GATE_OFF)
            ) u_ramp (
                .core_clk(core_clk),
                .reset(reset),
                .enable(ss_enable[r]),
                .tick(switch_tick),
                .fast_rate(switching_rate_select),
                .code(ref_dac_codes[r*SS_CODE_W +: SS_CODE_W]),
                .done(ss_done[r])
            );
        end
    endgenerate

    // Supervisor reset; the status word reads its release state
    logic sup_hold, sup_timed_out;
    assign sup_hold = !supervisor_sense_ok || !supply_ok ||
                      !enable_above || fault_reg || thermal_reg;
    assign sup_timed_out = sup_cnt_reg >= reset_time_reg;

    always_ff @(posedge core_clk) begin
        if (reset || sup_hold) begin
            sup_cnt_reg <= '0;
        end else if (!sup_timed_out) begin
            sup_cnt_reg <= sup_cnt_reg + CNT_ONE;
        end
    end

    // Open drain: the data level is always low, only the enable moves
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sup_oe_reg <= 1'b1;
            sup_out_reg <= 1'b0;
        end else begin
            sup_oe_reg <= sup_hold || !sup_timed_out;
            sup_out_reg <= 1'b0;
        end
    end

    // Register bus: write channel decode
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic wr_go, wr_fault, wr_reset, wr_status, wr_mapped;
    assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_fault = awaddr_reg == REG_FAULT_TIME;
    assign wr_reset = awaddr_reg == REG_RESET_TIME;
    assign wr_status = awaddr_reg == REG_STATUS;
    assign wr_mapped = wr_fault || wr_reset || wr_status;

    // Byte-lane merge of a timing register
    function automatic logic [CNT_W-1:0] merge_bytes(
        input logic [CNT_W-1:0] old_val,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [CNT_W-1:0] res;
        res = old_val;
        for (int b = 0; b < CNT_W / 8; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_bytes

    // Address and data may arrive in either order
    always_ff @(posedge core_clk) begin
        if (reset) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // Timing registers steer the fault timer and supervisor timeout
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_time_reg <= FAULT_INIT;
            reset_time_reg <= RESET_INIT;
        end else if (wr_go) begin
            if (wr_fault) begin
                fault_time_reg <= merge_bytes(fault_time_reg, wdata_reg,
                                              wstrb_reg);
            end
            if (wr_reset) begin
                reset_time_reg <= merge_bytes(reset_time_reg, wdata_reg,
                                              wstrb_reg);
            end
        end
    end

    // Status word shows live block state
    logic [31:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[ST_FAULT_BIT] = fault_reg;
        status_word[ST_THERMAL_BIT] = thermal_reg;
        status_word[ST_BUCK_BIT] = buck_en_reg;
        status_word[ST_RAIL_LSB +: NUM_REG-1] = ss_enable[NUM_REG-1:1];
        status_word[ST_SUP_REL_BIT] = !sup_oe_reg;
        status_word[ST_STATE_LSB +: 2] = state_reg;
        status_word[ST_SUPPLY_BIT] = supply_ok;
        status_word[ST_ENABLE_BIT] = enable_above;
    end

    // Read decode
    logic rd_status, rd_fault, rd_reset, rd_mapped;
    logic [31:0] rd_word;
    assign rd_status = s_axi_araddr == REG_STATUS;
    assign rd_fault = s_axi_araddr == REG_FAULT_TIME;
    assign rd_reset = s_axi_araddr == REG_RESET_TIME;
    assign rd_mapped = rd_status || rd_fault || rd_reset;
    assign rd_word = rd_status ? status_word :
                     rd_fault ? 32'(fault_time_reg) :
                     rd_reset ? 32'(reset_time_reg) : 32'h00000000;

    // Read answers one cycle after the address is taken
    always_ff @(posedge core_clk) begin
        if (reset) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Output wiring, every one from a flop
    assign high_side_gate_drive = hs_reg;
    assign low_side_gate_drive = ls_reg;
    assign step_down_enable = buck_en_reg;
    assign logic_rail_controller_enable = logic_en_reg;
    assign gamma_rail_controller_enable = seq_rail_reg[0];
    assign third_rail_controller_enable = seq_rail_reg[1];
    assign source_drive_rail_controller_enable = seq_rail_reg[2];
    assign gate_off_rail_controller_enable = seq_rail_reg[3];
    assign internal_supply_rail_enable = vl_en_reg;
    assign sequence_block_enable = seq_block_reg;
    assign delay_pin_current_enable = cur_en_reg;
    assign delay_pin_pulldown_enable = pulldown_reg;
    assign supervisor_reset_out = sup_out_reg;
    assign supervisor_reset_oe = sup_oe_reg;
    assign fault_latched = fault_reg;
    assign thermal_latched = thermal_reg;
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
endmodule : supply_startup_sequencer

// >>> tb/analog_model.sv
// Far-side model: oscillator tick and delay pin capacitor ramps
`timescale 1ns/1ps
module analog_model (
    input wire logic core_clk,
    input wire logic delay_pin_current_enable,
    input wire logic delay_pin_pulldown_enable,
    output logic switch_tick,
    output logic [3:0] sequence_delay_pin_reached
);
    logic tick_reg = 1'b0;
    logic [7:0] level_reg = 8'h00;
    // Pin charges while sourced, grounded when pulled down
    always @(posedge core_clk) begin
        tick_reg <= ~tick_reg;
        if (delay_pin_pulldown_enable)
            level_reg <= 8'h00;
        else if (delay_pin_current_enable && level_reg != 8'hff)
            level_reg <= level_reg + 8'h01;
    end
    // Staggered thresholds stand for four different capacitors
    assign switch_tick = tick_reg;
    assign sequence_delay_pin_reached = {level_reg > 8'h28,
        level_reg > 8'h1e, level_reg > 8'h14, level_reg > 8'h0a};
endmodule : analog_model

// >>> tb/seq_props.sv
// Port assertions for the supply startup sequencer
`timescale 1ns/1ps
module seq_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic enable_above,
    input wire logic supply_ok,
    input wire logic sequence_select,
    input wire logic thermal_trip,
    input wire logic supervisor_sense_ok,
    input wire logic high_side_gate_drive,
    input wire logic low_side_gate_drive,
    input wire logic step_down_enable,
    input wire logic sequence_block_enable,
    input wire logic delay_pin_current_enable,
    input wire logic delay_pin_pulldown_enable,
    input wire logic thermal_latched,
    input wire logic internal_supply_rail_enable,
    input wire logic supervisor_reset_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    en_off_a: assert property (
        !enable_above |=> !step_down_enable) else $error("rail on");
    gate_low_a: assert property (
        !supply_ok |=> !high_side_gate_drive && !low_side_gate_drive)
        else $error("gate driven");
    start_cond_a: assert property (
        step_down_enable |-> $past(supply_ok) && $past(enable_above))
        else $error("early start");
    block_with_a: assert property (
        sequence_block_enable == step_down_enable) else $error("split");
    pin_src_a: assert property (
        delay_pin_current_enable == ($past(sequence_select)
        && sequence_block_enable)) else $error("source wrong");
    pin_pull_a: assert property (
        delay_pin_pulldown_enable != delay_pin_current_enable)
        else $error("pull-down wrong");
    heat_off_a: assert property (
        thermal_trip |=> thermal_latched && !internal_supply_rail_enable)
        else $error("thermal missed");
    sup_hold_a: assert property (
        !supervisor_sense_ok || !enable_above |=> supervisor_reset_oe)
        else $error("reset released");
endmodule : seq_props
bind supply_startup_sequencer seq_props seq_props_inst (.*);

// >>> tb/tb_top.sv
// Self-checking bench for the supply startup sequencer
`timescale 1ns/1ps
module tb_top;
    import supply_seq_pkg::*;
    logic core_clk = 0, reset = 1, enable_above = 0, supply_ok = 0;
    logic sequence_select = 0, overcurrent_raw = 0, thermal_trip = 0;
    logic supervisor_sense_ok = 0, switching_rate_select = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [3:0] s_axi_wstrb = 4'hf, sequence_delay_pin_reached;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [5:0] rail_undervoltage = 0;
    logic switch_tick, pwm_high_request, pwm_low_request;
    logic high_side_gate_drive, low_side_gate_drive, step_down_enable;
    logic logic_rail_controller_enable, gamma_rail_controller_enable;
    logic third_rail_controller_enable, source_drive_rail_controller_enable;
    logic gate_off_rail_controller_enable, internal_supply_rail_enable;
    logic sequence_block_enable, delay_pin_current_enable, fault_latched;
    logic delay_pin_pulldown_enable, supervisor_reset_out, thermal_latched;
    logic supervisor_reset_oe, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [35:0] ref_dac_codes;
    int mismatches = 0, compares = 0, cycles = 0, t0, n;
    // Modulator asks for one gate or the other on every cycle
    assign pwm_high_request = switch_tick;
    assign pwm_low_request = ~switch_tick;
    supply_startup_sequencer #(.OC_FILTER_LEN(8), .FAULT_TIME_INIT(20),
        .RESET_TIME_INIT(20)) supply_startup_sequencer_inst (.*);
    analog_model analog_model_inst (.*);
    always #4 core_clk = ~core_clk;
    // Hang guard, well above the longest expected run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 9000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic summarize;
        $display("%0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic tk(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tk
    // One write or one read; each channel dropped once taken
    task automatic ax(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!(s_axi_bvalid && wr) && !(s_axi_rvalid && !wr));
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        tk(1);
    endtask : ax
    task automatic t_regs;
        ax(0, REG_FAULT_TIME, 0);
        chk(s_axi_rdata, 20);
        ax(1, REG_RESET_TIME, 32'hab00001e);
        chk(s_axi_bresp, RESP_OKAY);
        ax(0, REG_RESET_TIME, 0);
        chk(s_axi_rdata, 32'h1e);
        ax(0, 8'h0c, 0);
        chk({s_axi_rdata, s_axi_rresp}, {32'h0, RESP_SLVERR});
        $display("regs done");
    endtask : t_regs
    task automatic t_start;
        supply_ok <= 1;
        supervisor_sense_ok <= 1;
        sequence_select <= 1;
        tk(3);
        chk({step_down_enable, ref_dac_codes[35:30]}, 7'h20);
        enable_above <= 1;
        t0 = cycles;
        tk(2);
        chk({step_down_enable, sequence_block_enable}, 2'h3);
        tk(1);
        chk({delay_pin_current_enable, supervisor_reset_oe}, 2'h3);
        for (n = 0; n < 99 && !gamma_rail_controller_enable; n++) tk(1);
        chk(gamma_rail_controller_enable, 1);
        chk(third_rail_controller_enable, 0);
        for (n = 0; n < 3000 && !logic_rail_controller_enable; n++) tk(1);
        chk(cycles - t0 inside {[2046:2058]}, 1);
        chk(ref_dac_codes[5:0], 6'h20);
        for (n = 0; n < 200 && ref_dac_codes[35:30] != 0; n++) tk(1);
        chk({ref_dac_codes[35:30], supervisor_reset_oe}, 7'h00);
        chk(gate_off_rail_controller_enable, 1);
        $display("startup done");
    endtask : t_start
    task automatic t_fault;
        rail_undervoltage <= 6'h01;
        t0 = cycles;
        for (n = 0; n < 60 && !fault_latched; n++) tk(1);
        chk(cycles - t0 inside {[20:26]}, 1);
        tk(1);
        chk({step_down_enable, internal_supply_rail_enable}, 2'h1);
        chk({supervisor_reset_oe, supervisor_reset_out}, 2'h2);
        rail_undervoltage <= 0;
        enable_above <= 0;
        tk(1);
        enable_above <= 1;
        tk(3);
        chk({fault_latched, step_down_enable}, 2'h1);
        overcurrent_raw <= 1;
        tk(5);
        overcurrent_raw <= 0;
        tk(2);
        chk(fault_latched, 0);
        overcurrent_raw <= 1;
        t0 = cycles;
        for (n = 0; n < 30 && !fault_latched; n++) tk(1);
        chk(cycles - t0 inside {[7:11]}, 1);
        overcurrent_raw <= 0;
        sequence_select <= 0;
        tk(1);
        sequence_select <= 1;
        tk(3);
        chk(fault_latched, 0);
        $display("fault done");
    endtask : t_fault
    task automatic t_therm;
        supply_ok <= 0;
        tk(3);
        chk({high_side_gate_drive, low_side_gate_drive}, 2'h0);
        supply_ok <= 1;
        thermal_trip <= 1;
        tk(1);
        thermal_trip <= 0;
        enable_above <= 0;
        tk(1);
        enable_above <= 1;
        tk(3);
        chk({thermal_latched, internal_supply_rail_enable}, 2'h2);
        supply_ok <= 0;
        tk(1);
        supply_ok <= 1;
        tk(3);
        chk({thermal_latched, step_down_enable}, 2'h1);
        $display("thermal done");
    endtask : t_therm
    initial begin
        tk(3);
        reset <= 0;
        t_regs();
        t_start();
        t_fault();
        t_therm();
        summarize();
    end
endmodule : tb_top
